// file: rtl/root_port_pkg.sv
// package: register map, fields and timing constants of the root port block
package root_port_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses from the i/o base)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PORT0_OFFSET = 8'h10;
  localparam logic [7:0] PORT1_OFFSET = 8'h12;

  // ----------------------------------------------------------------------
  // field positions of port_state_control_reg
  // ----------------------------------------------------------------------
  localparam int BIT_ENABLE     = 2;
  localparam int BIT_LINE_DP    = 4;
  localparam int BIT_LINE_DM    = 5;
  localparam int BIT_RESUME     = 6;
  localparam int BIT_ALWAYS_ONE = 7;
  localparam int BIT_OC_ACTIVE  = 10;
  localparam int BIT_OC_IND     = 11;
  localparam int BIT_SUSPEND    = 12;

  localparam logic [15:0] PORT_RESET_VALUE = 16'h0080;
  localparam logic [15:0] WORD_ZERO        = 16'h0000;

  // ----------------------------------------------------------------------
  // frame length: base count plus the 7-bit adjust field
  // ----------------------------------------------------------------------
  localparam logic [13:0] FRAME_BASE_CLOCKS = 14'h2EA0; // 11936
  localparam logic [6:0]  FRAME_ADJ_RESET   = 7'h40;    // 64 -> 12000

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PORT_DISABLED,
    PORT_ENABLED,
    PORT_SUSPENDED
  } port_mode_t;

  typedef enum {
    SUSP_IDLE,
    SUSP_WAIT,
    SUSP_ACTIVE
  } susp_state_t;

  // per-port line and fault inputs
  typedef struct packed {
    logic dp;
    logic dm;
    logic oc_n;
    logic resume_k;
  } port_line_t;

  // per-port state
  typedef struct packed {
    logic        enable;
    logic        suspend_req;
    susp_state_t susp;
    logic        oc_ind;
    logic        oc_meta;
    logic        oc_sync;
    logic        oc_prev;
    logic        resume_det;
    logic [1:0]  line;
  } port_state_t;

endpackage

// file: rtl/usb_root_port_status_control.sv
// root hub port status and control logic for two downstream ports
`timescale 1ns/1ps
`default_nettype none

module usb_root_port_status_control #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // word-wide i/o register port
  input  wire logic                         io_write,
  input  wire logic                         io_read,
  input  wire logic [7:0]                   io_addr,
  input  wire logic [15:0]                  io_wdata,
  output logic      [15:0]                  io_rdata,
  // frame timing
  input  wire logic [6:0]                   frame_length_adjust_reg,
  output logic      [13:0]                  frame_length_clocks,
  // host command and schedule status
  input  wire logic                         global_suspend,
  input  wire logic                         global_reset,
  input  wire logic [NUM_PORTS-1:0]         port_reset,
  input  wire logic                         transaction_busy,
  input  wire logic                         babble_out,
  input  wire logic                         sof_sent,
  // downstream data path gating
  input  wire logic [NUM_PORTS-1:0]         tx_request,
  output logic      [NUM_PORTS-1:0]         tx_allow,
  output logic      [NUM_PORTS-1:0]         se0_allow,
  output logic      [NUM_PORTS-1:0]         sof_allow,
  output logic      [NUM_PORTS-1:0]         resume_detect_flag,
  // per-port line inputs
  input  wire root_port_pkg::port_line_t [NUM_PORTS-1:0] line_in,
  output root_port_pkg::port_mode_t [NUM_PORTS-1:0]      port_mode
);
  import root_port_pkg::*;

  typedef struct packed {
    port_state_t [NUM_PORTS-1:0] port;
    logic [13:0]                 frame_len;
    logic [15:0]                 rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [NUM_PORTS-1:0] wr_hit;
  logic [NUM_PORTS-1:0] rd_hit;
  logic [15:0]          word_view [NUM_PORTS];

  // ----------------------------------------------------------------------
  // address decode and read view
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_view
    localparam logic [7:0] OFFS = (p == 0) ? PORT0_OFFSET : PORT1_OFFSET;
    // only full words are decoded; no byte lanes exist
    assign wr_hit[p] = io_write && (io_addr == OFFS);
    assign rd_hit[p] = io_read && (io_addr == OFFS);
    always_comb begin
      word_view[p] = PORT_RESET_VALUE;
      word_view[p][BIT_ENABLE]    = state_reg.port[p].enable;
      word_view[p][BIT_LINE_DP]   = state_reg.port[p].line[0];
      word_view[p][BIT_LINE_DM]   = state_reg.port[p].line[1];
      word_view[p][BIT_RESUME]    = state_reg.port[p].resume_det;
      word_view[p][BIT_OC_ACTIVE] = state_reg.port[p].oc_sync;
      word_view[p][BIT_OC_IND]    = state_reg.port[p].oc_ind;
      // suspend reads one only once the port really suspended
      word_view[p][BIT_SUSPEND] =
        (state_reg.port[p].susp == SUSP_ACTIVE);
    end
  end

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = WORD_ZERO;
    // new adjust value takes effect for the next frame length
    state_next.frame_len =
      FRAME_BASE_CLOCKS + {7'h00, frame_length_adjust_reg};
    for (int p = 0; p < NUM_PORTS; p++) begin
      // two-flop synchroniser; only the second stage feeds the edge
      state_next.port[p].oc_meta = ~line_in[p].oc_n;
      state_next.port[p].oc_sync = state_reg.port[p].oc_meta;
      state_next.port[p].oc_prev = state_reg.port[p].oc_sync;
      // line status sampled; low bit plus line, high bit minus line
      state_next.port[p].line = {line_in[p].dm, line_in[p].dp};
      if (rd_hit[p]) begin
        state_next.rdata = word_view[p];
      end
      // write one clears the indicator; a new edge wins over the clear
      if (wr_hit[p] && io_wdata[BIT_OC_IND]) begin
        state_next.port[p].oc_ind = 1'b0;
      end
      if (state_reg.port[p].oc_sync && !state_reg.port[p].oc_prev) begin
        state_next.port[p].oc_ind = 1'b1;
      end
      if (wr_hit[p]) begin
        state_next.port[p].enable = io_wdata[BIT_ENABLE];
        // suspend request is masked off during global suspend
        state_next.port[p].suspend_req =
          io_wdata[BIT_SUSPEND] && !global_suspend;
      end
      // suspend sequencing: wait out a running transaction
      case (state_reg.port[p].susp)
        SUSP_IDLE: begin
          if (state_next.port[p].suspend_req &&
              state_next.port[p].enable) begin
            state_next.port[p].susp = SUSP_WAIT;
          end
        end
        SUSP_WAIT: begin
          if (!state_reg.port[p].suspend_req) begin
            state_next.port[p].susp = SUSP_IDLE;
          end else if (!transaction_busy) begin
            state_next.port[p].susp = SUSP_ACTIVE;
          end
        end
        SUSP_ACTIVE: begin
          if (!state_next.port[p].suspend_req ||
              !state_next.port[p].enable) begin
            state_next.port[p].susp = SUSP_IDLE;
          end
        end
        default: state_next.port[p].susp = SUSP_IDLE;
      endcase
      // resume stays detectable while suspended
      if (state_reg.port[p].susp == SUSP_ACTIVE &&
          line_in[p].resume_k) begin
        state_next.port[p].resume_det = 1'b1;
      end
      if (wr_hit[p] && !io_wdata[BIT_RESUME]) begin
        state_next.port[p].resume_det = 1'b0;
      end
      // resets return the port to disabled and idle
      if (port_reset[p] || global_reset) begin
        state_next.port[p].enable      = 1'b0;
        state_next.port[p].suspend_req = 1'b0;
        state_next.port[p].susp        = SUSP_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        state_reg.port[p].enable      <= 1'b0;
        state_reg.port[p].suspend_req <= 1'b0;
        state_reg.port[p].susp        <= SUSP_IDLE;
        state_reg.port[p].oc_ind      <= 1'b0;
        state_reg.port[p].oc_meta     <= 1'b0;
        state_reg.port[p].oc_sync     <= 1'b0;
        state_reg.port[p].oc_prev     <= 1'b0;
        state_reg.port[p].resume_det  <= 1'b0;
        state_reg.port[p].line        <= 2'h0;
      end
      state_reg.frame_len <= FRAME_BASE_CLOCKS + {7'h00, FRAME_ADJ_RESET};
      state_reg.rdata     <= WORD_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs: mode decode and downstream gating
  // ----------------------------------------------------------------------
  assign io_rdata            = state_reg.rdata;
  assign frame_length_clocks = state_reg.frame_len;
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_out
    logic susp_now;
    assign susp_now = (state_reg.port[p].susp == SUSP_ACTIVE);
    // mode from suspend and enable bits
    assign port_mode[p] = !state_reg.port[p].enable ? PORT_DISABLED :
                          susp_now ? PORT_SUSPENDED :
                          PORT_ENABLED;
    // suspended port passes nothing downstream but reset signalling
    assign tx_allow[p] = tx_request[p] && state_reg.port[p].enable &&
                         !susp_now;
    assign se0_allow[p] = port_reset[p] || global_reset;
    // frame starts stop once suspend is asked; a babbled out keeps them
    // allowed while the port waits to suspend, only for as long as babble_out stays high
    assign sof_allow[p] = state_reg.port[p].enable &&
      (state_reg.port[p].susp == SUSP_IDLE ||
      (state_reg.port[p].susp == SUSP_WAIT && babble_out));
    assign resume_detect_flag[p] = state_reg.port[p].resume_det;

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    sequence s_wait_busy;
      state_reg.port[p].susp == SUSP_WAIT && transaction_busy;
    endsequence
    a_suspend_waits: assert property (@(posedge clock) disable iff (rst)
      s_wait_busy |=> state_reg.port[p].susp != SUSP_ACTIVE)
      else $error("port suspended during a transaction");
    a_suspend_blocks: assert property (@(posedge clock) disable iff (rst)
      susp_now |-> !tx_allow[p])
      else $error("suspended port passed data");
    a_oc_sets: assert property (@(posedge clock) disable iff (rst)
      $rose(state_reg.port[p].oc_sync) |=> state_reg.port[p].oc_ind)
      else $error("overcurrent edge did not set indicator");
    a_oc_zero_write: assert property (@(posedge clock) disable iff (rst)
      state_reg.port[p].oc_ind && !(wr_hit[p] && io_wdata[BIT_OC_IND])
      |=> state_reg.port[p].oc_ind)
      else $error("indicator lost without a one write");
    a_oc_sync_path: assert property (@(posedge clock) disable iff (rst)
      ##2 state_reg.port[p].oc_sync == $past(~line_in[p].oc_n, 2))
      else $error("overcurrent synchroniser depth wrong");
    a_mode_decode: assert property (@(posedge clock) disable iff (rst)
      !state_reg.port[p].enable |-> port_mode[p] == PORT_DISABLED)
      else $error("disabled port reports other mode");
    a_susp_readback: assert property (@(posedge clock) disable iff (rst)
      rd_hit[p] |=> io_rdata[BIT_SUSPEND] == $past(susp_now))
      else $error("suspend read back early");
    a_resume_seen: assert property (@(posedge clock) disable iff (rst)
      susp_now && line_in[p].resume_k && !wr_hit[p]
      |=> state_reg.port[p].resume_det)
      else $error("resume missed while suspended");
    a_line_map: assert property (@(posedge clock) disable iff (rst)
      ##1 state_reg.port[p].line == {$past(line_in[p].dm),
      $past(line_in[p].dp)})
      else $error("line status bits swapped");
  end

  a_frame_len: assert property (@(posedge clock) disable iff (rst)
    ##1 frame_length_clocks ==
    FRAME_BASE_CLOCKS + {7'h00, $past(frame_length_adjust_reg)})
    else $error("frame length not base plus adjust");
  a_reset_state: assert property (@(posedge clock)
    $past(rst) && !rst |-> port_mode[0] == PORT_DISABLED &&
    port_mode[1] == PORT_DISABLED)
    else $error("port not disabled after reset");

endmodule

`default_nettype wire

// file: tb/usb_device_model.sv
// downstream device model: line levels, fault pin and wake-up signalling
`timescale 1ns/1ps
`default_nettype none

module usb_device_model (
  // device controls from the bench
  input  wire logic                 attach,
  input  wire logic                 fault,
  input  wire logic                 wake,
  // lines seen by the port
  output root_port_pkg::port_line_t line
);
  import root_port_pkg::*;

  // detached lines sit at se0 on the pull-downs, wake drives the k state
  always_comb begin
    line.dp       = attach & ~wake; // idle j: plus line high
    line.dm       = attach & wake;  // k state for resume
    line.oc_n     = ~fault;         // fault pin is active low
    line.resume_k = attach & wake;
  end
endmodule

`default_nettype wire

// file: tb/usb_root_port_status_control_tb_top.sv
// testbench: register and suspend checks of both ports, resume of port 0, overcurrent of port 1
`timescale 1ns/1ps
`default_nettype none

module usb_root_port_status_control_tb_top;
  import root_port_pkg::*;

  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic             io_write = 1'b0;
  logic             io_read = 1'b0;
  logic [7:0]       io_addr = 8'h00;
  logic [15:0]      io_wdata = 16'h0000;
  logic [15:0]      io_rdata;
  logic [6:0]       adj = 7'h40;
  logic [13:0]      flc;
  logic             gsusp = 1'b0;
  logic             greset = 1'b0;
  logic [1:0]       preset = 2'h0;
  logic             busy = 1'b0;
  logic             babble = 1'b0;
  logic [1:0]       tx_req = 2'h0;
  logic [1:0]       tx_allow;
  logic [1:0]       se0_allow;
  logic [1:0]       sof_allow;
  logic [1:0]       rdf;
  logic [1:0]       attach = 2'h0;
  logic [1:0]       fault = 2'h0;
  logic [1:0]       wake = 2'h0;
  port_line_t [1:0] line_in;
  port_mode_t [1:0] port_mode;
  int               err_count = 0;
  int               samples_checked = 0;
  int               cycles = 0;

  // 4 ns period
  always #2 clock = ~clock;

  usb_device_model m0 (.attach(attach[0]), .fault(fault[0]),
                       .wake(wake[0]), .line(line_in[0]));
  usb_device_model m1 (.attach(attach[1]), .fault(fault[1]),
                       .wake(wake[1]), .line(line_in[1]));

  usb_root_port_status_control dut (
    .clock(clock), .rst(rst), .io_write(io_write), .io_read(io_read),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .frame_length_adjust_reg(adj), .frame_length_clocks(flc),
    .global_suspend(gsusp), .global_reset(greset), .port_reset(preset),
    .transaction_busy(busy), .babble_out(babble), .sof_sent(1'b0),
    .tx_request(tx_req), .tx_allow(tx_allow), .se0_allow(se0_allow),
    .sof_allow(sof_allow), .resume_detect_flag(rdf), .line_in(line_in),
    .port_mode(port_mode));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string w, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // whole-word write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    io_write <= 1'b1;
    io_addr  <= a;
    io_wdata <= d;
    @(posedge clock);
    io_write <= 1'b0;
  endtask

  // read data is registered, so look one edge after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [15:0] m, e,
                    input string w);
    @(posedge clock);
    io_read <= 1'b1;
    io_addr <= a;
    @(posedge clock);
    io_read <= 1'b0;
    #1;
    chk(w, io_rdata & m, e);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic reset_and_frame;
    rd(8'h10, 16'hFFFF, 16'h0080, "port0 reset");
    rd(8'h12, 16'hFFFF, 16'h0080, "port1 reset");
    rd(8'h14, 16'hFFFF, 16'h0000, "unmapped");
    chk("frame reset", {2'h0, flc}, 16'h2EE0);
    @(posedge clock) adj <= 7'h00;
    tick(2);
    chk("frame min", {2'h0, flc}, 16'h2EA0);
    @(posedge clock) adj <= 7'h7F;
    tick(2);
    chk("frame max", {2'h0, flc}, 16'h2F1F);
  endtask

  task automatic suspend_resume;
    @(posedge clock) attach <= 2'h1;
    tick(3);
    rd(8'h12, 16'h0030, 16'h0000, "port1 idle line");
    wr(8'h10, 16'h0004);
    @(posedge clock) tx_req <= 2'h1;
    busy <= 1'b1;
    babble <= 1'b1;
    tick(1);
    chk("mode on", {14'h0, port_mode[0]}, 16'(PORT_ENABLED));
    wr(8'h10, 16'h1004);
    tick(3);
    rd(8'h10, 16'hFFFF, 16'h0094, "suspend pending");
    chk("tx in wait", {15'h0, tx_allow[0]}, 16'h0001);
    chk("sof in wait", {15'h0, sof_allow[0]}, 16'h0001);
    @(posedge clock) busy <= 1'b0;
    babble <= 1'b0;
    for (int i = 0; i < 20 && port_mode[0] !== PORT_SUSPENDED; i++) tick(1);
    chk("mode susp", {14'h0, port_mode[0]}, 16'(PORT_SUSPENDED));
    chk("tx blocked", {15'h0, tx_allow[0]}, 16'h0000);
    chk("sof blocked", {15'h0, sof_allow[0]}, 16'h0000);
    rd(8'h10, 16'hFFFF, 16'h1094, "suspended");
    @(posedge clock) wake <= 2'h1;
    for (int i = 0; i < 20 && rdf[0] !== 1'b1; i++) tick(1);
    chk("resume flag", {15'h0, rdf[0]}, 16'h0001);
    rd(8'h10, 16'h0060, 16'h0060, "resume line");
    @(posedge clock) preset <= 2'h1;
    tick(2);
    chk("se0 in reset", {15'h0, se0_allow[0]}, 16'h0001);
    chk("reset mode", {14'h0, port_mode[0]}, 16'(PORT_DISABLED));
    @(posedge clock) preset <= 2'h0;
    wake <= 2'h0;
    tx_req <= 2'h0;
  endtask

  task automatic global_suspend_write;
    @(posedge clock) gsusp <= 1'b1;
    wr(8'h12, 16'h1004);
    tick(3);
    rd(8'h12, 16'h1004, 16'h0004, "gsusp refused");
    @(posedge clock) gsusp <= 1'b0;
    greset <= 1'b1;
    tick(2);
    chk("greset mode", {14'h0, port_mode[1]}, 16'(PORT_DISABLED));
    @(posedge clock) greset <= 1'b0;
  endtask

  task automatic overcurrent;
    @(posedge clock) fault <= 2'h2;
    tick(5);
    rd(8'h12, 16'h0C00, 16'h0C00, "oc set");
    wr(8'h12, 16'h0000);
    rd(8'h12, 16'h0C00, 16'h0C00, "oc zero write");
    wr(8'h12, 16'h0800);
    tick(4);
    rd(8'h12, 16'h0C00, 16'h0400, "oc cleared once");
    @(posedge clock) fault <= 2'h0;
    tick(5);
    rd(8'h12, 16'h0C00, 16'h0000, "oc gone");
    rd(8'h10, 16'h0C00, 16'h0000, "port0 no oc");
    @(posedge clock) fault <= 2'h2;
    tick(5);
    rd(8'h12, 16'h0C00, 16'h0C00, "oc again");
  endtask

  // ----------------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    reset_and_frame();
    suspend_resume();
    global_suspend_write();
    overcurrent();
    complete_run();
  end

  // the whole run takes about a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end
endmodule

`default_nettype wire
